//--- src/tnp_pkg.sv
// ==========================================================================
// Shared constants of the transmit nibble payload input block
package tnp_pkg;

  // ==========================================================================
  // Register map
  localparam logic [15:0] TEST_CTRL_ADDR    = 16'h110C;
  localparam logic [15:0] STATUS_ADDR       = 16'h1104;
  localparam logic [15:0] TIMING_MODE_ADDR  = 16'h1108;

  // Test control fields
  localparam int          OH_SRC_BIT        = 7;
  localparam int          RX_GAP_BIT        = 6;
  localparam int          TX_GAP_BIT        = 5;
  localparam int          PRBS_LOCK_BIT     = 4;
  localparam int          PRBS_DET_BIT      = 3;
  localparam int          PRBS_GEN_BIT      = 2;
  localparam logic [7:0]  TEST_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  TEST_CTRL_WMASK   = 8'hEC;

  // ==========================================================================
  // Timing modes of the nibble-parallel payload interface
  localparam logic [2:0]  MODE_LOOP         = 3'h4;
  localparam logic [2:0]  MODE_LOCAL_SLAVE  = 3'h5;
  localparam logic [2:0]  MODE_LOCAL_MASTER = 3'h6;
  localparam logic [2:0]  MODE_RESET        = MODE_LOOP;

  // ==========================================================================
  // Frame geometry
  localparam int          FRAME_BYTES       = 537;
  localparam int          PAYLOAD_BYTES     = 530;
  localparam int          OH_BYTES          = FRAME_BYTES - PAYLOAD_BYTES;
  localparam int          NIB_PER_BYTE      = 2;
  localparam int          BITS_PER_NIB      = 4;
  localparam int          FRAME_NIBS        = FRAME_BYTES * NIB_PER_BYTE;
  localparam int          OH_NIBS           = OH_BYTES * NIB_PER_BYTE;
  localparam int          NIB_IDX_W         = 11;
  localparam int          SYNC_STAGES       = 3;

endpackage : tnp_pkg

//--- src/tnp_sync.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Three-stage pin synchroniser; output follows once stages two and three agree
module tnp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] nxt_out;

  // Per bit: take the new level only when the last two stages match
  assign nxt_out = (stage2_ff & stage3_ff) | (out_ff & (stage2_ff | stage3_ff));

  // Shift chain; first stage is read by the second only
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff   <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
      out_ff    <= '0;
    end else begin
      meta_ff   <= async_in;
      stage2_ff <= meta_ff;
      stage3_ff <= stage2_ff;
      out_ff    <= nxt_out;
    end
  end

  assign sync_out = out_ff;

endmodule // tnp_sync
`default_nettype wire

//--- src/tnp_frame_pos.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Nibble position inside one frame, with overhead slot flags
module tnp_frame_pos #(
  parameter int FRAME_NIBS = tnp_pkg::FRAME_NIBS,
  parameter int OH_NIBS    = tnp_pkg::OH_NIBS
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rstn,
  input  wire logic                           advance,
  input  wire logic                           realign,
  output logic [tnp_pkg::NIB_IDX_W-1:0]       nib_idx,
  output logic                                cur_is_oh,
  output logic                                next_is_oh
);

  localparam logic [tnp_pkg::NIB_IDX_W-1:0] LAST_IDX = (tnp_pkg::NIB_IDX_W)'(FRAME_NIBS - 1);
  localparam logic [tnp_pkg::NIB_IDX_W-1:0] OH_END   = (tnp_pkg::NIB_IDX_W)'(OH_NIBS);

  logic [tnp_pkg::NIB_IDX_W-1:0] idx_ff;
  logic [tnp_pkg::NIB_IDX_W-1:0] nxt_idx;
  logic [tnp_pkg::NIB_IDX_W-1:0] succ_idx;

  // Overhead occupies the leading slots of the frame
  function automatic logic slot_is_oh(input logic [tnp_pkg::NIB_IDX_W-1:0] i);
    slot_is_oh = (i < OH_END);
  endfunction

  // Wrap after the last slot; realign restarts at the first slot
  assign succ_idx   = (idx_ff == LAST_IDX) ? '0 : idx_ff + 1'b1;
  assign nxt_idx    = realign ? '0 : (advance ? succ_idx : idx_ff);
  assign cur_is_oh  = slot_is_oh(idx_ff);
  assign next_is_oh = slot_is_oh(succ_idx);
  assign nib_idx    = idx_ff;

  // Position register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idx_ff <= '0;
    end else begin
      idx_ff <= nxt_idx;
    end
  end

endmodule // tnp_frame_pos
`default_nettype wire

//--- src/tnp_tx_nibble_if.sv
// Functional notes
// - Gapped mode: indicator pin becomes demand clock
// - Demand pulse suppressed in overhead slots
// - Nibble captured on demand-clock falling edge
// - Loop timing uses recovered line clock
// - Local timing uses local reference clock
// - Test register bit 5 enables gapped mode
// - Transmit enable separate from receive enable
// - Frame is 537 bytes, 7 overhead
// - Overhead slots filled from overhead path
// - Nibble modes are 4 through 6
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module tnp_tx_nibble_if (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        recovered_line_clock,
  input  wire logic        local_transmit_ref_clock,
  input  wire logic        frame_sync_in,
  input  wire logic [3:0]  tx_payload_nibble_in,
  output logic             payload_nibble_clock,
  output logic             overhead_indicator_out,
  output logic             frame_start_out,
  input  wire logic [3:0]  overhead_nibble_in,
  input  wire logic        rx_prbs_lock,
  output logic             overhead_source_select,
  output logic             rx_demand_clock_enable,
  output logic             prbs_gen_enable,
  output logic             prbs_det_enable,
  output logic [3:0]       framed_nibble_out,
  output logic             framed_nibble_valid,
  output logic             framed_is_overhead
);

  // ==========================================================================
  // Declarations
  logic [7:0]                    test_ff;
  logic [2:0]                    mode_ff;
  logic [7:0]                    rdata_ff;
  logic [7:0]                    pay_cnt_ff;
  logic                          prev_clk_ff;
  logic                          prev_fsync_ff;
  logic [1:0]                    div_ff;
  logic                          realign_ff;
  logic                          oh_out_ff;
  logic                          fstart_ff;
  logic [3:0]                    framed_ff;
  logic                          fvalid_ff;
  logic                          fis_oh_ff;
  logic [6:0]                    sync_bus;
  logic                          rec_s;
  logic                          loc_s;
  logic                          fsync_s;
  logic [3:0]                    nib_s;
  logic                          sel_clk;
  logic                          clk_rise;
  logic                          nib_start;
  logic                          nib_fall;
  logic                          nib_clk_hi;
  logic                          tx_gap;
  logic                          cur_is_oh;
  logic                          next_is_oh;
  logic [tnp_pkg::NIB_IDX_W-1:0] nib_idx;
  logic                          wr_test;
  logic                          wr_mode;
  logic                          mode_ok;
  logic [7:0]                    test_view;
  logic [7:0]                    nxt_rdata;
  logic                          nxt_oh_out;
  logic                          fsync_rise;
  logic                          pay_take;
  logic                          oh_take;

  // ==========================================================================
  // Pin synchronisers for both clocks, the slave frame sync and the nibble
  tnp_sync #(
    .WIDTH    (7)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in ({frame_sync_in, tx_payload_nibble_in, recovered_line_clock,
                local_transmit_ref_clock}),
    .sync_out (sync_bus)
  );

  assign loc_s   = sync_bus[0];
  assign rec_s   = sync_bus[1];
  assign nib_s   = sync_bus[5:2];
  assign fsync_s = sync_bus[6];

  // ==========================================================================
  // Register decode
  assign wr_test   = reg_wr && (reg_addr == tnp_pkg::TEST_CTRL_ADDR);
  assign wr_mode   = reg_wr && (reg_addr == tnp_pkg::TIMING_MODE_ADDR);
  assign mode_ok   = (reg_wdata[2:0] >= tnp_pkg::MODE_LOOP) &&
                     (reg_wdata[2:0] <= tnp_pkg::MODE_LOCAL_MASTER);
  assign test_view = {test_ff[7:5], rx_prbs_lock, test_ff[3:2], 2'h0};
  assign nxt_rdata = !reg_rd ? 8'h00 :
                     (reg_addr == tnp_pkg::TEST_CTRL_ADDR)   ? test_view :
                     (reg_addr == tnp_pkg::TIMING_MODE_ADDR) ? {5'h00, mode_ff} :
                     (reg_addr == tnp_pkg::STATUS_ADDR)      ? pay_cnt_ff : 8'h00;

  // Control bits of the test register
  assign tx_gap                 = test_ff[tnp_pkg::TX_GAP_BIT];
  assign rx_demand_clock_enable = test_ff[tnp_pkg::RX_GAP_BIT];
  assign overhead_source_select = test_ff[tnp_pkg::OH_SRC_BIT];
  assign prbs_det_enable        = test_ff[tnp_pkg::PRBS_DET_BIT];
  assign prbs_gen_enable        = test_ff[tnp_pkg::PRBS_GEN_BIT];

  // Register writes; only writable fields, out-of-range modes ignored
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      test_ff <= tnp_pkg::TEST_CTRL_RESET;
      mode_ff <= tnp_pkg::MODE_RESET;
    end else begin
      if (wr_test) begin
        test_ff <= reg_wdata & tnp_pkg::TEST_CTRL_WMASK;
      end
      if (wr_mode && mode_ok) begin
        mode_ff <= reg_wdata[2:0];
      end
    end
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ==========================================================================
  // Timing source and nibble clock
  assign sel_clk    = (mode_ff == tnp_pkg::MODE_LOOP) ? rec_s : loc_s;
  assign clk_rise   = sel_clk && !prev_clk_ff;
  assign nib_start  = clk_rise && (div_ff == 2'h3);
  assign nib_fall   = clk_rise && (div_ff == 2'h1);
  assign nib_clk_hi = !div_ff[1];
  assign fsync_rise = fsync_s && !prev_fsync_ff;

  // Bit clock edges divided by four into the nibble clock
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_clk_ff   <= 1'b0;
      prev_fsync_ff <= 1'b0;
      div_ff        <= 2'h0;
    end else begin
      prev_clk_ff   <= sel_clk;
      prev_fsync_ff <= fsync_s;
      div_ff        <= clk_rise ? div_ff + 2'h1 : div_ff;
    end
  end

  assign payload_nibble_clock = nib_clk_hi;

  // ==========================================================================
  // Frame position; frame slave realigns on the sync pin at next slot start
  tnp_frame_pos #(
    .FRAME_NIBS (tnp_pkg::FRAME_NIBS),
    .OH_NIBS    (tnp_pkg::OH_NIBS)
  ) u_pos (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .advance    (nib_start),
    .realign    (nib_start && realign_ff),
    .nib_idx    (nib_idx),
    .cur_is_oh  (cur_is_oh),
    .next_is_oh (next_is_oh)
  );

  // Pending realign request, held until a slot boundary
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      realign_ff <= 1'b0;
    end else if (fsync_rise && (mode_ff == tnp_pkg::MODE_LOCAL_SLAVE)) begin
      realign_ff <= 1'b1;
    end else if (nib_start) begin
      realign_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Indicator pin: level for the coming slot, or gapped demand clock
  assign nxt_oh_out = tx_gap ? (nib_clk_hi && !cur_is_oh)
                             : next_is_oh;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      oh_out_ff <= 1'b0;
      fstart_ff <= 1'b0;
    end else begin
      oh_out_ff <= nxt_oh_out;
      fstart_ff <= nib_start && (mode_ff != tnp_pkg::MODE_LOCAL_SLAVE) &&
                   (nib_idx == (tnp_pkg::NIB_IDX_W)'(tnp_pkg::FRAME_NIBS - 1));
    end
  end

  assign overhead_indicator_out = oh_out_ff;
  assign frame_start_out        = fstart_ff;

  // ==========================================================================
  // Capture at the falling nibble edge: payload from pins, overhead elsewhere
  assign pay_take = nib_fall && !cur_is_oh;
  assign oh_take  = nib_fall && cur_is_oh;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      framed_ff  <= 4'h0;
      fvalid_ff  <= 1'b0;
      fis_oh_ff  <= 1'b0;
      pay_cnt_ff <= 8'h00;
    end else begin
      fvalid_ff  <= pay_take || oh_take;
      fis_oh_ff  <= oh_take ? 1'b1 : (pay_take ? 1'b0 : fis_oh_ff);
      framed_ff  <= pay_take ? nib_s : (oh_take ? overhead_nibble_in : framed_ff);
      pay_cnt_ff <= pay_take ? pay_cnt_ff + 8'h01 : pay_cnt_ff;
    end
  end

  assign framed_nibble_out   = framed_ff;
  assign framed_nibble_valid = fvalid_ff;
  assign framed_is_overhead  = fis_oh_ff;

  // ==========================================================================
  // Checks
  gap_pulse_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (tx_gap && nib_clk_hi && !cur_is_oh) |=> overhead_indicator_out)
    else $error("demand pulse missing in payload slot");
  gap_suppress_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (tx_gap && cur_is_oh) |=> !overhead_indicator_out)
    else $error("demand pulse seen in overhead slot");
  ind_level_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    !tx_gap |=> (overhead_indicator_out == $past(next_is_oh)))
    else $error("indicator does not flag coming slot");
  capture_fall_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (nib_fall && !cur_is_oh) |=> (framed_nibble_valid && !framed_is_overhead &&
                                  framed_nibble_out == $past(nib_s)))
    else $error("payload nibble not captured at fall");
  oh_source_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (nib_fall && cur_is_oh) |=> (framed_is_overhead &&
                                 framed_nibble_out == $past(overhead_nibble_in)))
    else $error("overhead slot not from overhead path");
  frame_len_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (nib_start && nib_idx == 11'd1073 && !realign_ff) |=> (nib_idx == 11'd0))
    else $error("frame length is not 537 bytes");
  oh_count_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    cur_is_oh == (nib_idx < 11'd14))
    else $error("overhead slot count wrong");
  loop_src_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (mode_ff == tnp_pkg::MODE_LOOP) |-> (sel_clk == rec_s))
    else $error("loop timing not on recovered clock");
  local_src_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (mode_ff != tnp_pkg::MODE_LOOP) |-> (sel_clk == loc_s))
    else $error("local timing not on reference clock");
  gap_write_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_test |=> (tx_gap == $past(reg_wdata[5])))
    else $error("gapped enable not written from bit 5");
  rx_separate_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_test |=> (rx_demand_clock_enable == $past(reg_wdata[6])))
    else $error("receive enable not from its own bit");
  mode_range_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    (mode_ff >= 3'h4) && (mode_ff <= 3'h6))
    else $error("timing mode outside nibble range");

  // Payload counter moves on payload captures only
  pay_count_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    pay_take |=> (pay_cnt_ff == $past(pay_cnt_ff) + 8'h01))
    else $error("payload counter missed a capture");
  oh_no_count_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    oh_take |=> (pay_cnt_ff == $past(pay_cnt_ff)))
    else $error("overhead slot counted as payload");

  // Read data is zero outside the cycle after a read strobe
  rdata_idle_a : assert property (@(posedge sys_clk) disable iff (!rstn)
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data stands without a read");

  gap_frame_c : cover property (@(posedge sys_clk) disable iff (!rstn)
    tx_gap && nib_start && nib_idx == 11'd13);
  nongap_cap_c : cover property (@(posedge sys_clk) disable iff (!rstn)
    !tx_gap && pay_take);
  slave_align_c : cover property (@(posedge sys_clk) disable iff (!rstn)
    realign_ff && nib_start);
  gap_capture_c : cover property (@(posedge sys_clk) disable iff (!rstn)
    tx_gap && pay_take);
  master_slot_c : cover property (@(posedge sys_clk) disable iff (!rstn)
    (mode_ff == tnp_pkg::MODE_LOCAL_MASTER) && nib_start);

endmodule // tnp_tx_nibble_if
`default_nettype wire

//--- tb/tnp_far_end.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Far-side terminal equipment feeding payload nibbles
module tnp_far_end (
  input  wire logic       gapped_mode,
  input  wire logic       payload_nibble_clock,
  input  wire logic       overhead_indicator_out,
  output logic      [3:0] tx_payload_nibble_in
);
  logic       hold_ff;
  logic [3:0] ng_cnt;
  logic [3:0] gp_cnt;

  initial begin
    hold_ff = 1'b0;
    ng_cnt  = 4'h0;
    gp_cnt  = 4'h0;
  end

  // Sample the indicator on each nibble clock fall
  always @(negedge payload_nibble_clock) begin
    hold_ff <= overhead_indicator_out;
  end

  // Non-gapped: next nibble at the rise unless told to hold
  always @(posedge payload_nibble_clock) begin
    if (!gapped_mode && !hold_ff) begin
      ng_cnt <= ng_cnt + 4'h1;
    end
  end

  // Gapped: next nibble on every demand clock rise
  always @(posedge overhead_indicator_out) begin
    if (gapped_mode) begin
      gp_cnt <= gp_cnt + 4'h1;
    end
  end

  assign tx_payload_nibble_in = gapped_mode ? gp_cnt : ng_cnt;
endmodule // tnp_far_end
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Self-checking bench of the transmit nibble payload input block
module tb_top;
  logic        sys_clk, rstn, reg_wr, reg_rd, frame_sync_in, rx_prbs_lock;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        recovered_line_clock, local_transmit_ref_clock, rec_en, loc_en;
  logic [3:0]  tx_payload_nibble_in, overhead_nibble_in, framed_nibble_out;
  logic        payload_nibble_clock, overhead_indicator_out, frame_start_out;
  logic        overhead_source_select, rx_demand_clock_enable;
  logic        prbs_gen_enable, prbs_det_enable, framed_nibble_valid;
  logic        framed_is_overhead, gap_mode, mon_en, cnt_en, have_last, prev_ind;
  logic [3:0]  last_nib;
  logic [7:0]  s0, s1;
  logic [2:0]  cur;
  int          error_cnt, check_count, cyc, n_dem, n_pay, n_oh, r, i;
  logic [2:0]  t_mode [5] = '{3'h4, 3'h4, 3'h6, 3'h6, 3'h5};
  logic        t_rec  [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic        t_run  [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  tnp_tx_nibble_if uut (
    .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .recovered_line_clock, .local_transmit_ref_clock, .frame_sync_in,
    .tx_payload_nibble_in, .payload_nibble_clock, .overhead_indicator_out,
    .frame_start_out, .overhead_nibble_in, .rx_prbs_lock,
    .overhead_source_select, .rx_demand_clock_enable, .prbs_gen_enable,
    .prbs_det_enable, .framed_nibble_out, .framed_nibble_valid,
    .framed_is_overhead
  );

  tnp_far_end far (
    .gapped_mode(gap_mode), .payload_nibble_clock, .overhead_indicator_out,
    .tx_payload_nibble_in
  );

  // System clock and two unrelated link clocks that may be stopped
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    recovered_line_clock = 1'b0;
    forever #200 recovered_line_clock = rec_en ^ recovered_line_clock;
  end
  initial begin
    local_transmit_ref_clock = 1'b0;
    #73;
    forever #200 local_transmit_ref_clock = loc_en ^ local_transmit_ref_clock;
  end

  // ==========================================================================
  // Compare, bus and counting tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic rdv(input logic [15:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask
  task automatic count_rise(input int n, output int cnt);
    logic p;
    cnt = 0;
    p = payload_nibble_clock;
    repeat (n) begin
      @(negedge sys_clk);
      if (payload_nibble_clock && !p) cnt++;
      p = payload_nibble_clock;
    end
  endtask
  task automatic wait_fs();
    int k;
    k = 0;
    @(negedge sys_clk);
    while (frame_start_out !== 1'b1 && k < 40000) begin
      @(negedge sys_clk);
      k++;
    end
    chk({15'h0000, frame_start_out}, 16'h0001);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watch captures and demand clock rises
  always @(negedge sys_clk) begin
    if (cnt_en && overhead_indicator_out && !prev_ind) n_dem++;
    prev_ind = overhead_indicator_out;
    if (framed_nibble_valid === 1'b1 && framed_is_overhead === 1'b1) begin
      chk({12'h000, framed_nibble_out}, {12'h000, overhead_nibble_in});
      if (cnt_en) n_oh++;
    end else if (framed_nibble_valid === 1'b1) begin
      if (cnt_en) n_pay++;
      if (mon_en && have_last) chk({12'h000, framed_nibble_out}, {12'h000, last_nib + 4'h1});
      last_nib  = framed_nibble_out;
      have_last = 1'b1;
    end
  end

  // Cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      test_done();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {rstn, reg_wr, reg_rd, frame_sync_in, rx_prbs_lock, gap_mode} = 6'h00;
    {mon_en, cnt_en, have_last, prev_ind} = 4'h0;
    {rec_en, loc_en} = 2'b11;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    overhead_nibble_in = 4'h9;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(tnp_pkg::TEST_CTRL_ADDR, 8'h00);
    rd(tnp_pkg::TIMING_MODE_ADDR, 8'h04);
    @(posedge sys_clk);
    rx_prbs_lock <= 1'b1;
    wr(tnp_pkg::TEST_CTRL_ADDR, 8'hFF);
    rd(tnp_pkg::TEST_CTRL_ADDR, 8'hFC);
    chk({12'h000, overhead_source_select, rx_demand_clock_enable, prbs_det_enable, prbs_gen_enable}, 16'h000F);
    wr(tnp_pkg::TEST_CTRL_ADDR, 8'h20);
    rd(tnp_pkg::TEST_CTRL_ADDR, 8'h30);
    chk({12'h000, overhead_source_select, rx_demand_clock_enable, prbs_det_enable, prbs_gen_enable}, 16'h0000);
    cur = 3'h4;
    for (i = 0; i < 8; i++) begin
      wr(tnp_pkg::TIMING_MODE_ADDR, {5'h00, 3'(i)});
      if (i >= 4 && i <= 6) cur = 3'(i);
      rd(tnp_pkg::TIMING_MODE_ADDR, {5'h00, cur});
    end
    rd(16'h1100, 8'h00);
    $display("register test done");
    for (i = 0; i < 5; i++) begin
      wr(tnp_pkg::TIMING_MODE_ADDR, {5'h00, t_mode[i]});
      rec_en <= t_rec[i];
      loc_en <= ~t_rec[i];
      frame_sync_in <= (i == 4);
      count_rise(40, r);
      count_rise(320, r);
      chk({15'h0000, r >= 9 && r <= 11}, {15'h0000, t_run[i]});
    end
    {rec_en, loc_en} <= 2'b11;
    frame_sync_in <= 1'b0;
    $display("clock source test done");
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    {have_last, mon_en, cnt_en} = 3'b011;
    n_dem = 0;
    rd(tnp_pkg::STATUS_ADDR, 8'h00);
    repeat (1300) @(posedge sys_clk);
    chk({15'h0000, n_dem <= 1}, 16'h0001);
    $display("non-gapped test done");
    mon_en = 1'b0;
    cnt_en = 1'b0;
    wr(tnp_pkg::TEST_CTRL_ADDR, 8'h20);
    gap_mode <= 1'b1;
    overhead_nibble_in <= 4'h6;
    repeat (200) @(posedge sys_clk);
    mon_en = 1'b1;
    wait_fs();
    {n_dem, n_pay, n_oh} = {32'd0, 32'd0, 32'd0};
    cnt_en = 1'b1;
    rdv(tnp_pkg::STATUS_ADDR, s0);
    wait_fs();
    cnt_en = 1'b0;
    rdv(tnp_pkg::STATUS_ADDR, s1);
    chk({8'h00, 8'(s1 - s0)}, {8'h00, 8'(tnp_pkg::PAYLOAD_BYTES * 2)});
    chk(16'(n_dem), 16'(tnp_pkg::PAYLOAD_BYTES * 2));
    chk(16'(n_pay), 16'd1060);
    chk(16'(n_oh), 16'd14);
    $display("gapped frame test done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
